//--- bench/haptic_host_control_port_test.sv
`default_nettype none
module haptic_host_control_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CALN = 20;
  logic clk_sys, rst_n, fuse_init_n, scl, sda_m, en_pin, pwm_in, a, v;
  logic sda_out, sda_oe_n, rm_ol, lra_ol, drv_clk, cal_busy, standby;
  logic [7:0] q;
  int miscompares, samples_checked, cycles, n;
  wire logic sda = sda_m & (sda_oe_n | sda_out);
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end
  hhcp_top #(.CAL_CYCLES(CALN)) hhcp_top_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .fuse_init_n(fuse_init_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .en_pin(en_pin), .pwm_in(pwm_in), .rm_ol_active(rm_ol),
    .lra_ol_active(lra_ol), .lra_drive_clk(drv_clk), .cal_busy(cal_busy),
    .standby_out(standby));
  hhcp_host hhcp_host_i (.scl(scl), .sda_m(sda_m), .sda(sda));
  // Register write of one byte
  task automatic wr(input logic [7:0] r, input logic [7:0] d);
    hhcp_host_i.start();
    hhcp_host_i.byte_io(8'hB4, 1'b1, q, a);
    `CHK("addr ack", 1'b0, a)
    hhcp_host_i.byte_io(r, 1'b1, q, a);
    `CHK("reg ack", 1'b0, a)
    hhcp_host_i.byte_io(d, 1'b1, q, a);
    `CHK("data ack", 1'b0, a)
    hhcp_host_i.stop();
  endtask
  // Register read of one byte into q
  task automatic rd(input logic [7:0] r);
    hhcp_host_i.start();
    hhcp_host_i.byte_io(8'hB4, 1'b1, q, a);
    hhcp_host_i.byte_io(r, 1'b1, q, a);
    hhcp_host_i.start();
    hhcp_host_i.byte_io(8'hB5, 1'b1, q, a);
    `CHK("rd addr ack", 1'b0, a)
    hhcp_host_i.byte_io(8'hFF, 1'b1, q, a);
    hhcp_host_i.stop();
  endtask
  // Foreign address, mode wake, sequential write and read
  task automatic t_bus();
    logic [7:0] s[4] = '{8'hB4, 8'h1B, 8'hA5, 8'h3C};
    logic [7:0] e[3] = '{8'hA5, 8'h3C, 8'h00};
    hhcp_host_i.start();
    hhcp_host_i.byte_io(8'hB6, 1'b1, q, a);
    `CHK("foreign ack", 1'b1, a)
    hhcp_host_i.stop();
    wr(8'h01, 8'h07);
    `CHK("standby", 1'b0, standby)
    rd(8'h01);
    `CHK("mode", 8'h07, q)
    hhcp_host_i.start();
    foreach (s[i]) begin
      hhcp_host_i.byte_io(s[i], 1'b1, q, a);
      `CHK("seq ack", 1'b0, a)
    end
    hhcp_host_i.start();
    hhcp_host_i.byte_io(8'hB4, 1'b1, q, a);
    hhcp_host_i.byte_io(8'h1B, 1'b1, q, a);
    hhcp_host_i.start();
    hhcp_host_i.byte_io(8'hB5, 1'b1, q, a);
    foreach (e[i]) begin
      hhcp_host_i.byte_io(8'hFF, i == 2, q, a);
      `CHK("seq rd", e[i], q)
    end
    hhcp_host_i.stop();
  endtask
  // Open-loop selection, period field and pulse-input divider
  task automatic t_ol();
    wr(8'h1A, 8'h00);
    wr(8'h1D, 8'h20);
    `CHK("rm ol", 1'b1, rm_ol)
    wr(8'h1A, 8'h80);
    `CHK("rm ol off", 1'b0, rm_ol)
    wr(8'h1D, 8'h01);
    `CHK("lra ol", 1'b1, lra_ol)
    wr(8'h20, 8'h02);
    @(posedge drv_clk);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (drv_clk === 1'b1);
    `CHK("period", 2 * hhcp_pkg::OL_UNIT_CYC, n)
    wr(8'h01, 8'h03);
    repeat (2) begin
      v = drv_clk;
      n = 0;
      while (drv_clk === v && n < 200) begin
        @(posedge clk_sys) #2 pwm_in = 1'b1;
        repeat (3) @(posedge clk_sys);
        #2 pwm_in = 1'b0;
        repeat (4) @(posedge clk_sys);
        n++;
      end
    end
    `CHK("pwm half", 64, n)
    wr(8'h1D, 8'h03);
    @(posedge drv_clk);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (drv_clk === 1'b1);
    `CHK("analog period", 2 * hhcp_pkg::OL_UNIT_CYC, n)
  endtask
  // Calibration with rotating-mass type and a forced fault
  task automatic t_cal();
    @(posedge clk_sys) #2 en_pin = 1'b1;
    wr(8'h01, 8'h07);
    wr(8'h1A, 8'h00);
    wr(8'h1B, 8'h05);
    wr(8'h16, 8'h10);
    wr(8'h17, 8'h05);
    wr(8'h0C, 8'h01);
    `CHK("busy", 1'b1, cal_busy)
    repeat (CALN + 5) @(posedge clk_sys);
    `CHK("busy end", 1'b0, cal_busy)
    rd(8'h0C);
    `CHK("launch", 8'h00, q)
    rd(8'h00);
    `CHK("fault", 1'b1, q[3])
    rd(8'h18);
    `CHK("res18", 8'h10, q)
    rd(8'h19);
    `CHK("res19", 8'h10, q)
    rd(8'h1A);
    `CHK("res1a", 8'h01, q)
    @(posedge clk_sys) #2 en_pin = 1'b0;
    rd(8'h16);
    `CHK("kept", 8'h10, q)
  endtask
  // Fuse program once, second attempt ignored, soft reset reloads
  task automatic t_fuse();
    wr(8'h1E, 8'h01);
    rd(8'h1E);
    `CHK("fuse st", 1'b1, q[2])
    wr(8'h16, 8'h33);
    wr(8'h1E, 8'h01);
    wr(8'h01, 8'h80);
    rd(8'h16);
    `CHK("reload", 8'h10, q)
    rd(8'h1E);
    `CHK("fuse st2", 1'b1, q[2])
  endtask
  task automatic finish_test();
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // System clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  // Reset, then the scenarios
  initial begin
    {rst_n, fuse_init_n, en_pin, pwm_in} = 4'h0;
    {miscompares, samples_checked, cycles} = '0;
    repeat (20) @(posedge clk_sys);
    #2 {rst_n, fuse_init_n} = 2'h3;
    repeat (6) @(posedge clk_sys);
    t_bus();
    t_ol();
    t_cal();
    t_fuse();
    finish_test();
  end
endmodule
`default_nettype wire

//--- bench/hhcp_host.sv
`default_nettype none
module hhcp_host (
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idles released, pulled high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Data set in SCL low, sampled in SCL high
  task automatic bit_io(input logic b, output logic r);
    #80 sda_m = b;
    #120 scl = 1'b1;
    #80 r = sda;
    #40 scl = 1'b0;
  endtask
  // Start or repeated start, aligned just after a system clock rising edge
  task automatic start();
    #((62 - $time % 40) % 40);
    #80 sda_m = 1'b1;
    #120 scl = 1'b1;
    #120 sda_m = 1'b0;
    #120 scl = 1'b0;
  endtask
  // Stop leaves both lines released
  task automatic stop();
    #80 sda_m = 1'b0;
    #120 scl = 1'b1;
    #120 sda_m = 1'b1;
  endtask
  // Eight bits MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] d, input logic ao,
    output logic [7:0] q, output logic ai);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ao, ai);
  endtask
endmodule
`default_nettype wire

//--- verilog/hhcp_fuse_if.sv
`default_nettype none
interface hhcp_fuse_if;
  logic prog;
  hhcp_pkg::hhcp_fuse_t wdata;
  hhcp_pkg::hhcp_fuse_t rdata;
  logic programmed;
  modport ctrl (output prog, output wdata, input rdata, input programmed);
  modport mem (input prog, input wdata, output rdata, output programmed);
endinterface
`default_nettype wire

//--- verilog/hhcp_fuse_mem.sv
`default_nettype none
module hhcp_fuse_mem (
  input wire logic clk_sys,
  input wire logic fuse_init_n,
  hhcp_fuse_if.mem fuse
);
  hhcp_pkg::hhcp_fuse_t cells_reg;
  hhcp_pkg::hhcp_fuse_t rdata_reg;
  logic burnt_reg;

  // One-shot burn; blank state only from the factory init pin
  always_ff @(posedge clk_sys or negedge fuse_init_n) begin
    if (!fuse_init_n) begin
      cells_reg <= hhcp_pkg::OTP_RST;
      burnt_reg <= 1'b0;
    end else if (fuse.prog && !burnt_reg) begin // RL23
      cells_reg <= fuse.wdata;
      burnt_reg <= 1'b1;
    end
  end

  // Registered read port
  always_ff @(posedge clk_sys or negedge fuse_init_n) begin
    if (!fuse_init_n) begin
      rdata_reg <= hhcp_pkg::OTP_RST;
    end else begin
      rdata_reg <= cells_reg;
    end
  end

  assign fuse.rdata = rdata_reg;
  assign fuse.programmed = burnt_reg;

  AST_FUSE_ONCE: assert property ( // RL23
    @(posedge clk_sys) disable iff (!fuse_init_n)
    burnt_reg |=> ($stable(cells_reg) && burnt_reg)
  ) else $error("fuse cells changed after programming");
endmodule
`default_nettype wire

//--- verilog/hhcp_pkg.sv
// Overview of operation
// RL1 - Host starts write: address, direction 0
// RL2 - Acknowledge own address with direction bit
// RL3 - Register-number byte follows, device acknowledges it
// RL4 - Acknowledge every written data byte until stop
// RL5 - Sequential write advances register from start point
// RL6 - Answer only slave address 0x5A
// RL7 - Read begins with write of register number
// RL8 - Repeated start, direction 1, named register returned
// RL9 - Host ends read with not-acknowledge, stop
// RL10 - Read keeps sending while host acknowledges
// RL11 - Rotating-mass open loop: type 0, bit set
// RL12 - Linear open loop: type 1, bit set
// RL13 - Pulse input: drive frequency is input over 128
// RL14 - No pulse input: period from 7-bit field
// RL15 - Calibration ignores linear-only inputs for rotating mass
// RL16 - Calibration end overwrites result registers
// RL17 - Write 0x07 to mode: wake, calibrate mode
// RL18 - Launch bit starts calibration, clears when done
// RL19 - Fault flag reports calibration outcome
// RL20 - Host configures calibration inputs beforehand
// RL21 - Host raises enable pin before calibration writes
// RL22 - Registers kept in idle or enable low
// RL23 - Fuse memory programs only once
// RL24 - Fuse program write; status reads 1 after
// RL25 - Reset reloads fuse values into fuse registers
// RL26 - Foreign address: data line stays released
// RL27 - Read pointer advances after each sent byte
`default_nettype none
package hhcp_pkg;
  // Bus address and timing
  localparam logic [6:0] SLAVE_ADDR = 7'h5A;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned CAL_TIME_US = 1000;
  localparam int unsigned CAL_CYC = CAL_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned OL_UNIT_NS = 100;
  localparam logic [7:0] OL_UNIT_CYC = 8'((OL_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned PWM_DIV = 128;
  localparam logic [5:0] PWM_HALF_M1 = 6'(PWM_DIV / 2 - 1);

  // Register offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_LAUNCH = 8'h0C;
  localparam logic [7:0] REG_RATED = 8'h16;
  localparam logic [7:0] REG_FB_CTRL = 8'h1A;
  localparam logic [7:0] REG_CTRL1 = 8'h1B;
  localparam logic [7:0] REG_CTRL2 = 8'h1C;
  localparam logic [7:0] REG_CTRL3 = 8'h1D;
  localparam logic [7:0] REG_FUSE = 8'h1E;
  localparam logic [7:0] REG_OL_PERIOD = 8'h20;

  // Field positions
  localparam int unsigned STATUS_FAULT_BIT = 3;
  localparam int unsigned MODE_RESET_BIT = 7;
  localparam int unsigned MODE_STANDBY_BIT = 6;
  localparam int unsigned LAUNCH_BIT = 0;
  localparam int unsigned FB_TYPE_BIT = 7;
  localparam int unsigned CTRL3_RM_OL_BIT = 5;
  localparam int unsigned CTRL3_ANALOG_BIT = 1;
  localparam int unsigned CTRL3_LRA_OL_BIT = 0;
  localparam int unsigned FUSE_STATUS_BIT = 2;
  localparam int unsigned FUSE_PROG_BIT = 0;

  // Fuse-backed word indices within 0x16..0x1A
  localparam int unsigned OTP_WORDS = 5;
  localparam int unsigned OTP_RATED = 0;
  localparam int unsigned OTP_CLAMP = 1;
  localparam int unsigned OTP_COMP = 2;
  localparam int unsigned OTP_BEMF = 3;
  localparam int unsigned OTP_FB = 4;

  // Operating modes
  localparam logic [2:0] MODE_PWM = 3'h3;
  localparam logic [2:0] MODE_CAL = 3'h7;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h40;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [6:0] PERIOD_RST = 7'h00;
  localparam logic [3:0] SYNC_RST = 4'h3;

  typedef logic [OTP_WORDS-1:0][7:0] hhcp_fuse_t;
  localparam hhcp_fuse_t OTP_RST = '0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_REG = 4'h3,
    ST_REG_ACK = 4'h4,
    ST_WDATA = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA = 4'h7,
    ST_RDATA_ACK = 4'h8
  } hhcp_state_e;
endpackage
`default_nettype wire

//--- verilog/hhcp_top.sv
`default_nettype none
module hhcp_top #(
  parameter int unsigned CAL_CYCLES = hhcp_pkg::CAL_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fuse_init_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic en_pin,
  input wire logic pwm_in,
  output logic rm_ol_active,
  output logic lra_ol_active,
  output logic lra_drive_clk,
  output logic cal_busy,
  output logic standby_out
);
  localparam int unsigned CAL_W = $clog2(CAL_CYCLES + 1);

  logic [3:0] sync1_reg, sync2_reg, sync3_reg;
  logic scl, sda, scl_rise, scl_fall, start_det, stop_det, en_s, pwm_rise;
  hhcp_pkg::hhcp_state_e state_reg, state_next;
  logic [3:0] bitcnt_reg, bitcnt_next;
  logic [7:0] shift_reg, shift_next, ptr_reg, ptr_next, rd_data;
  logic rw_reg, rw_next, nack_reg, nack_next, oe_n_reg, oe_n_next, wr_en;
  logic addr_match;
  logic [7:0] mode_reg, ctrl1_reg, ctrl2_reg, ctrl3_reg, status_val, otp_off;
  logic [6:0] period_reg;
  logic launch_reg, fault_reg, sw_rst_reg, load_pend_reg, load_go_reg;
  hhcp_pkg::hhcp_fuse_t otp_reg;
  logic [2:0] otp_idx;
  logic otp_hit, wr_mode, wr_launch, wr_otp, wr_ctrl1, wr_ctrl2, wr_ctrl3, wr_fuse, wr_period;
  logic is_lra, cal_start, cal_done, cal_busy_reg, cal_fault;
  logic [CAL_W-1:0] cal_cnt_reg;
  logic [7:0] lra_term, cal_comp, cal_bemf;
  logic [5:0] pwm_cnt_reg;
  logic [7:0] unit_cnt_reg;
  logic [6:0] per_cnt_reg;
  logic pwm_phase_reg, ol_phase_reg, unit_tick, pwm_in_use;
  logic rm_ol_reg, lra_ol_reg, lra_clk_reg;

  hhcp_fuse_if fuse_bus ();

  hhcp_fuse_mem u_fuse (
    .clk_sys(clk_sys),
    .fuse_init_n(fuse_init_n),
    .fuse(fuse_bus.mem)
  );

  // Pin synchronisers: scl, sda, enable, pulse input
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= hhcp_pkg::SYNC_RST;
      sync2_reg <= hhcp_pkg::SYNC_RST;
      sync3_reg <= hhcp_pkg::SYNC_RST;
    end else begin
      sync1_reg <= {pwm_in, en_pin, sda_in, scl_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Bus edge and condition detection
  assign scl = sync2_reg[0];
  assign sda = sync2_reg[1];
  assign en_s = sync2_reg[2];
  assign scl_rise = scl && !sync3_reg[0];
  assign scl_fall = !scl && sync3_reg[0];
  assign start_det = scl && sync3_reg[0] && sync3_reg[1] && !sda;
  assign stop_det = scl && sync3_reg[0] && !sync3_reg[1] && sda;
  assign pwm_rise = sync2_reg[3] && !sync3_reg[3];
  assign addr_match = (shift_reg[7:1] == hhcp_pkg::SLAVE_ADDR); // RL6

  // Slave sequencer: address, register number, write and read bytes
  always_comb begin
    state_next = state_reg;
    bitcnt_next = bitcnt_reg;
    shift_next = shift_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    nack_next = nack_reg;
    oe_n_next = oe_n_reg;
    wr_en = 1'b0;
    if (start_det) begin
      state_next = hhcp_pkg::ST_ADDR;
      bitcnt_next = 4'h0;
      oe_n_next = 1'b1;
    end else if (stop_det) begin
      state_next = hhcp_pkg::ST_IDLE;
      oe_n_next = 1'b1;
    end else begin
      unique case (state_reg)
        hhcp_pkg::ST_IDLE: begin
          oe_n_next = 1'b1;
        end
        hhcp_pkg::ST_ADDR, hhcp_pkg::ST_REG, hhcp_pkg::ST_WDATA: begin
          if (scl_rise && bitcnt_reg != 4'h8) begin
            shift_next = {shift_reg[6:0], sda};
            bitcnt_next = bitcnt_reg + 4'h1;
          end else if (scl_fall && bitcnt_reg == 4'h8) begin
            bitcnt_next = 4'h0;
            if (state_reg == hhcp_pkg::ST_ADDR) begin
              if (addr_match) begin
                state_next = hhcp_pkg::ST_ADDR_ACK; // RL2
                rw_next = shift_reg[0];
                oe_n_next = 1'b0;
              end else begin
                state_next = hhcp_pkg::ST_IDLE; // RL26
              end
            end else if (state_reg == hhcp_pkg::ST_REG) begin
              state_next = hhcp_pkg::ST_REG_ACK; // RL3
              ptr_next = shift_reg;
              oe_n_next = 1'b0;
            end else begin
              state_next = hhcp_pkg::ST_WDATA_ACK; // RL4
              wr_en = 1'b1;
              ptr_next = ptr_reg + 8'h01; // RL5
              oe_n_next = 1'b0;
            end
          end
        end
        hhcp_pkg::ST_ADDR_ACK, hhcp_pkg::ST_REG_ACK, hhcp_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            if (state_reg == hhcp_pkg::ST_ADDR_ACK && rw_reg) begin
              state_next = hhcp_pkg::ST_RDATA; // RL8
              shift_next = rd_data;
              oe_n_next = rd_data[7];
            end else begin
              state_next = (state_reg == hhcp_pkg::ST_ADDR_ACK) ?
                hhcp_pkg::ST_REG : hhcp_pkg::ST_WDATA;
              oe_n_next = 1'b1;
            end
          end
        end
        hhcp_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (bitcnt_reg == 4'h7) begin
              state_next = hhcp_pkg::ST_RDATA_ACK;
              oe_n_next = 1'b1;
              ptr_next = ptr_reg + 8'h01; // RL27
              bitcnt_next = 4'h0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_n_next = shift_reg[6];
              bitcnt_next = bitcnt_reg + 4'h1;
            end
          end
        end
        hhcp_pkg::ST_RDATA_ACK: begin
          if (scl_rise) begin
            nack_next = sda;
          end else if (scl_fall) begin
            if (nack_reg) begin
              state_next = hhcp_pkg::ST_IDLE;
            end else begin
              state_next = hhcp_pkg::ST_RDATA; // RL10
              shift_next = rd_data;
              oe_n_next = rd_data[7];
            end
          end
        end
        default: begin
          state_next = hhcp_pkg::ST_IDLE;
          oe_n_next = 1'b1;
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= hhcp_pkg::ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      nack_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bitcnt_reg <= bitcnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      nack_reg <= nack_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_reg;

  // Write decode; wr_en carries the byte still in shift_reg
  assign otp_off = ptr_reg - hhcp_pkg::REG_RATED;
  assign otp_idx = otp_off[2:0];
  assign otp_hit = (ptr_reg >= hhcp_pkg::REG_RATED) && (ptr_reg <= hhcp_pkg::REG_FB_CTRL);
  assign wr_mode = wr_en && ptr_reg == hhcp_pkg::REG_MODE;
  assign wr_launch = wr_en && ptr_reg == hhcp_pkg::REG_LAUNCH;
  assign wr_otp = wr_en && otp_hit;
  assign wr_ctrl1 = wr_en && ptr_reg == hhcp_pkg::REG_CTRL1;
  assign wr_ctrl2 = wr_en && ptr_reg == hhcp_pkg::REG_CTRL2;
  assign wr_ctrl3 = wr_en && ptr_reg == hhcp_pkg::REG_CTRL3;
  assign wr_fuse = wr_en && ptr_reg == hhcp_pkg::REG_FUSE;
  assign wr_period = wr_en && ptr_reg == hhcp_pkg::REG_OL_PERIOD;

  // Read select; unmapped offsets read zero
  assign status_val = {4'h0, fault_reg, 3'h0};
  assign rd_data = (ptr_reg == hhcp_pkg::REG_STATUS) ? status_val :
                   (ptr_reg == hhcp_pkg::REG_MODE) ? mode_reg :
                   (ptr_reg == hhcp_pkg::REG_LAUNCH) ? {7'h00, launch_reg} :
                   otp_hit ? otp_reg[otp_idx] :
                   (ptr_reg == hhcp_pkg::REG_CTRL1) ? ctrl1_reg :
                   (ptr_reg == hhcp_pkg::REG_CTRL2) ? ctrl2_reg :
                   (ptr_reg == hhcp_pkg::REG_CTRL3) ? ctrl3_reg :
                   (ptr_reg == hhcp_pkg::REG_FUSE) ? {5'h00, fuse_bus.programmed, 2'h0} : // RL24
                   (ptr_reg == hhcp_pkg::REG_OL_PERIOD) ? {1'b0, period_reg} : 8'h00;

  // Control registers; the enable pin never clears them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= hhcp_pkg::MODE_RST;
      ctrl1_reg <= hhcp_pkg::CTRL_RST;
      ctrl2_reg <= hhcp_pkg::CTRL_RST;
      ctrl3_reg <= hhcp_pkg::CTRL_RST;
      period_reg <= hhcp_pkg::PERIOD_RST;
      sw_rst_reg <= 1'b0;
    end else if (sw_rst_reg) begin // RL22
      mode_reg <= hhcp_pkg::MODE_RST;
      ctrl1_reg <= hhcp_pkg::CTRL_RST;
      ctrl2_reg <= hhcp_pkg::CTRL_RST;
      ctrl3_reg <= hhcp_pkg::CTRL_RST;
      period_reg <= hhcp_pkg::PERIOD_RST;
      sw_rst_reg <= 1'b0;
    end else begin
      if (wr_mode) mode_reg <= {1'b0, shift_reg[6:0]}; // RL17
      sw_rst_reg <= wr_mode && shift_reg[hhcp_pkg::MODE_RESET_BIT];
      if (wr_ctrl1) ctrl1_reg <= shift_reg;
      if (wr_ctrl2) ctrl2_reg <= shift_reg;
      if (wr_ctrl3) ctrl3_reg <= shift_reg;
      if (wr_period) period_reg <= shift_reg[6:0];
    end
  end

  // Launch bit and fault flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      launch_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (sw_rst_reg) begin
      launch_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else begin
      if (wr_launch) launch_reg <= shift_reg[hhcp_pkg::LAUNCH_BIT];
      else if (cal_done) launch_reg <= 1'b0; // RL18
      if (cal_done) fault_reg <= cal_fault; // RL19
    end
  end

  // Fuse reload one cycle after hardware reset release, two cycles after soft reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_pend_reg <= 1'b1;
      load_go_reg <= 1'b0;
    end else begin
      load_pend_reg <= sw_rst_reg;
      load_go_reg <= load_pend_reg;
    end
  end

  // Fuse-backed registers 0x16..0x1A
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      otp_reg <= hhcp_pkg::OTP_RST;
    end else if (load_go_reg) begin
      otp_reg <= fuse_bus.programmed ? fuse_bus.rdata : hhcp_pkg::OTP_RST; // RL25
    end else if (cal_done) begin
      otp_reg[hhcp_pkg::OTP_COMP] <= cal_comp; // RL16
      otp_reg[hhcp_pkg::OTP_BEMF] <= cal_bemf;
      otp_reg[hhcp_pkg::OTP_FB][1:0] <= is_lra ? 2'h2 : 2'h1;
    end else if (wr_otp) begin
      otp_reg[otp_idx] <= shift_reg;
    end
  end

  assign fuse_bus.prog = wr_fuse && shift_reg[hhcp_pkg::FUSE_PROG_BIT]; // RL24
  assign fuse_bus.wdata = otp_reg;

  // Calibration engine
  assign is_lra = otp_reg[hhcp_pkg::OTP_FB][hhcp_pkg::FB_TYPE_BIT];
  assign cal_start = launch_reg && !cal_busy_reg && en_s && // RL21
                     mode_reg[2:0] == hhcp_pkg::MODE_CAL &&
                     !mode_reg[hhcp_pkg::MODE_STANDBY_BIT];
  assign cal_done = cal_busy_reg && cal_cnt_reg == CAL_W'(CAL_CYCLES - 1);
  assign lra_term = is_lra ? {3'h0, ctrl1_reg[4:0]} : 8'h00; // RL15
  assign cal_comp = otp_reg[hhcp_pkg::OTP_RATED] + {5'h00, otp_reg[hhcp_pkg::OTP_FB][6:4]};
  assign cal_bemf = otp_reg[hhcp_pkg::OTP_RATED] + lra_term;
  assign cal_fault = otp_reg[hhcp_pkg::OTP_CLAMP] < otp_reg[hhcp_pkg::OTP_RATED];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_busy_reg <= 1'b0;
      cal_cnt_reg <= '0;
    end else if (cal_start) begin
      cal_busy_reg <= 1'b1; // RL18
      cal_cnt_reg <= '0;
    end else if (cal_busy_reg) begin
      cal_busy_reg <= !cal_done;
      cal_cnt_reg <= cal_cnt_reg + CAL_W'(1);
    end
  end

  // Open-loop drive clock: pulse input over 128, or period field
  assign pwm_in_use = mode_reg[2:0] == hhcp_pkg::MODE_PWM &&
                      !ctrl3_reg[hhcp_pkg::CTRL3_ANALOG_BIT];
  assign unit_tick = unit_cnt_reg == hhcp_pkg::OL_UNIT_CYC - 8'h01;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwm_cnt_reg <= 6'h00;
      pwm_phase_reg <= 1'b0;
    end else if (pwm_rise) begin
      pwm_cnt_reg <= pwm_cnt_reg + 6'h01;
      if (pwm_cnt_reg == hhcp_pkg::PWM_HALF_M1) pwm_phase_reg <= !pwm_phase_reg; // RL13
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_reg <= 8'h00;
      per_cnt_reg <= 7'h00;
      ol_phase_reg <= 1'b0;
    end else begin
      unit_cnt_reg <= unit_tick ? 8'h00 : unit_cnt_reg + 8'h01;
      if (unit_tick && period_reg != 7'h00) begin
        if (per_cnt_reg + 7'h01 >= period_reg) begin
          per_cnt_reg <= 7'h00;
          ol_phase_reg <= !ol_phase_reg; // RL14
        end else begin
          per_cnt_reg <= per_cnt_reg + 7'h01;
        end
      end
    end
  end

  // Registered mode outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rm_ol_reg <= 1'b0;
      lra_ol_reg <= 1'b0;
      lra_clk_reg <= 1'b0;
    end else begin
      rm_ol_reg <= !is_lra && ctrl3_reg[hhcp_pkg::CTRL3_RM_OL_BIT]; // RL11
      lra_ol_reg <= is_lra && ctrl3_reg[hhcp_pkg::CTRL3_LRA_OL_BIT]; // RL12
      lra_clk_reg <= lra_ol_reg && (pwm_in_use ? pwm_phase_reg : ol_phase_reg);
    end
  end

  assign rm_ol_active = rm_ol_reg;
  assign lra_ol_active = lra_ol_reg;
  assign lra_drive_clk = lra_clk_reg;
  assign cal_busy = cal_busy_reg;
  assign standby_out = mode_reg[hhcp_pkg::MODE_STANDBY_BIT];

  AST_ADDR_ACK: assert property ( // RL2
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == hhcp_pkg::ST_ADDR_ACK) |-> (sda_oe_n == 1'b0)
  ) else $error("address acknowledge not driven");

  AST_FOREIGN_ADDR: assert property ( // RL26
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == hhcp_pkg::ST_ADDR && scl_fall && bitcnt_reg == 4'h8 && !addr_match &&
     !start_det && !stop_det) |=> (state_reg == hhcp_pkg::ST_IDLE && sda_oe_n)
  ) else $error("foreign address was answered");

  AST_WRITE_ADVANCE: assert property ( // RL5
    @(posedge clk_sys) disable iff (!rst_n)
    wr_en |=> (ptr_reg == $past(ptr_reg) + 8'h01 && state_reg == hhcp_pkg::ST_WDATA_ACK)
  ) else $error("write pointer did not advance");

  AST_READ_ADVANCE: assert property ( // RL27
    @(posedge clk_sys) disable iff (!rst_n)
    (state_reg == hhcp_pkg::ST_RDATA && scl_fall && bitcnt_reg == 4'h7 && !start_det &&
     !stop_det) |=> (ptr_reg == $past(ptr_reg) + 8'h01 && sda_oe_n)
  ) else $error("read pointer did not advance");

  AST_RM_OPEN_LOOP: assert property ( // RL11
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_ctrl3 && shift_reg[hhcp_pkg::CTRL3_RM_OL_BIT] && !is_lra && !wr_otp && !sw_rst_reg &&
     !load_go_reg) |=> ##1 rm_ol_active
  ) else $error("rotating-mass open loop not entered");

  AST_MODE_WAKE: assert property ( // RL17
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_mode && shift_reg == 8'h07 && !sw_rst_reg) |=>
      (mode_reg[2:0] == hhcp_pkg::MODE_CAL && !standby_out)
  ) else $error("mode write 0x07 did not select calibration");

  AST_LAUNCH_CLEAR: assert property ( // RL18
    @(posedge clk_sys) disable iff (!rst_n)
    (cal_done && !wr_launch && !sw_rst_reg) |=> (!launch_reg && !cal_busy)
  ) else $error("launch bit not cleared at calibration end");

  AST_CAL_ERM: assert property ( // RL15
    @(posedge clk_sys) disable iff (!rst_n)
    (cal_done && !is_lra && !load_go_reg) |=>
      (otp_reg[hhcp_pkg::OTP_BEMF] == $past(otp_reg[hhcp_pkg::OTP_RATED]))
  ) else $error("linear-only input used for rotating mass");

  AST_FAULT_FLAG: assert property ( // RL19
    @(posedge clk_sys) disable iff (!rst_n)
    (cal_done && !sw_rst_reg) |=> (fault_reg == $past(cal_fault))
  ) else $error("fault flag does not match calibration");

  AST_FUSE_STATUS: assert property ( // RL24
    @(posedge clk_sys) disable iff (!rst_n)
    fuse_bus.prog |=> ##1 fuse_bus.programmed [*3]
  ) else $error("fuse status did not read one");
endmodule
`default_nettype wire
